// ---- common/pvt_pkg.sv ----
/*
 Constants for the panel video timing source: line and frame counts,
 mode encodings and mode-change timing.
 Assumes a 50 MHz system clock; pixel clock is derived by a divider.
*/
// Notes on behaviour
// - Frame rate times line and frame totals keeps pixel clock within 60 to 77 MHz; the divider here gives 12.5 MHz from the 50 MHz clock.
// - Any spread of the pixel clock stays within two percent of nominal.
// - Spread modulation rate is at most 200 kHz.
// - Nominal 50 Hz 2D frame rate stays between 47 and 53 Hz; code gives 2D50 the same vertical total as 2D60.
// - Nominal 60 Hz 2D frame rate stays between 57 and 62.5 Hz.
// - 2D frames carry 1080 active lines and 35 to 300 blank lines.
// - Every line carries 960 active clocks and 90 to 190 blank clocks.
// - 3D vertical totals are fixed: 1350/270 at 50 Hz, 1125/45 at 60 Hz.
// - 3D frame rate is held exactly at 50 or 60 Hz.
// - Black interval around a mode change lasts more than 650 ms.
// - Successive 2D/3D switches are more than 500 ms apart.
// - All interface outputs are actively driven while panel supply is on.
// - With supply off, outputs are held low; no drive before supply is up.
// - Backlight is enabled after panel runs and disabled before shutdown.
// - Pixels of each line go round-robin over four ports, port one first.
package pvt_pkg;
	localparam int unsigned H_ACTIVE     = 960;
	localparam int unsigned H_BLANK_MIN  = 90;
	localparam int unsigned H_BLANK_MAX  = 190;
	localparam int unsigned H_BLANK_TYP  = 140;
	localparam int unsigned V_ACTIVE     = 1080;
	localparam int unsigned V_BLANK_MIN  = 35;
	localparam int unsigned V_BLANK_MAX  = 300;
	localparam int unsigned V_BLANK_TYP  = 45;
	localparam int unsigned V_BLANK_3D50 = 270;
	localparam int unsigned V_BLANK_3D60 = 45;
	localparam int unsigned NUM_PORTS    = 4;
	localparam int unsigned CNT_W        = 11;
	localparam int unsigned SYS_CLK_HZ   = 50000000;
	localparam int unsigned SWITCH_GAP_MS = 500;
	localparam int unsigned BLACK_MS      = 650;
	localparam int unsigned SWITCH_GAP_CYC = SWITCH_GAP_MS * (SYS_CLK_HZ / 1000) + 1;
	localparam int unsigned BLACK_CYC      = BLACK_MS * (SYS_CLK_HZ / 1000) + 1;
	localparam int unsigned BL_DELAY_CYC   = 50000;
	localparam int unsigned PIX_DIV        = 2;
	localparam logic [1:0]  MODE_2D50 = 2'h0;
	localparam logic [1:0]  MODE_2D60 = 2'h1;
	localparam logic [1:0]  MODE_3D50 = 2'h2;
	localparam logic [1:0]  MODE_3D60 = 2'h3;
endpackage

// ---- logic/pvt_counter.sv ----
/*
 Horizontal and vertical raster counters advanced by a pixel enable.
 Assumes totals are held steady while running.
*/
`timescale 1ns/10ps
module pvt_counter #(
	parameter int unsigned W = 11
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	// Control
	input  wire logic         pix_en,
	input  wire logic         run,
	input  wire logic [W-1:0] h_total,
	input  wire logic [W-1:0] v_total,
	// Position
	output logic      [W-1:0] h_cnt,
	output logic      [W-1:0] v_cnt,
	output logic              frame_end
);
	logic [W-1:0] h_reg;
	logic [W-1:0] h_next;
	logic [W-1:0] v_reg;
	logic [W-1:0] v_next;

	always_comb begin
		h_next = h_reg;
		v_next = v_reg;
		if (!run) begin
			h_next = '0;
			v_next = '0;
		end else if (pix_en) begin
			if (h_reg == h_total - W'(1)) begin
				h_next = '0;
				v_next = (v_reg == v_total - W'(1)) ? '0 : v_reg + W'(1);
			end else begin
				h_next = h_reg + W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			h_reg <= '0;
			v_reg <= '0;
		end else begin
			h_reg <= h_next;
			v_reg <= v_next;
		end
	end

	assign h_cnt = h_reg;
	assign v_cnt = v_reg;
	assign frame_end = run && pix_en && (h_reg == h_total - W'(1))
		&& (v_reg == v_total - W'(1));
endmodule

// ---- logic/pvt_source.sv ----
/*
 Video timing source for a four-port 3840x1080 panel: raster timing,
 data enable, four-port pixel split, power and backlight sequencing and
 guarded 2D/3D mode switching.
 Assumes pixel data is supplied on the same clock, four pixels per pixel
 clock, and a supply-good level arriving from outside the clock domain.
*/
`timescale 1ns/10ps
module pvt_source #(
	parameter int unsigned PIX_W     = 30,
	parameter int unsigned GAP_CYC   = pvt_pkg::SWITCH_GAP_CYC,
	parameter int unsigned BLACK_CYC = pvt_pkg::BLACK_CYC,
	parameter int unsigned BL_CYC    = pvt_pkg::BL_DELAY_CYC,
	parameter int unsigned H_BLANK   = pvt_pkg::H_BLANK_TYP,
	parameter int unsigned V_BLANK2D = pvt_pkg::V_BLANK_TYP
) (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         nrst,
	// Supply and control
	input  wire logic                         supply_good,
	input  wire logic                         enable,
	input  wire logic [1:0]                   mode_req,
	// Pixel input, four per pixel clock
	input  wire logic [4*PIX_W-1:0]           pix_in,
	output logic                              pix_take,
	// Panel side
	output logic                              pix_clk,
	output logic                              data_en,
	output logic [PIX_W-1:0]                  port_data [4],
	output logic                              backlight_on,
	// Status
	output logic [1:0]                        mode_cur,
	output logic                              switch_busy
);
	typedef enum logic [3:0] {
		PVT_OFF   = 4'h1,
		PVT_RUN   = 4'h2,
		PVT_LIGHT = 4'h4,
		PVT_WAIT  = 4'h8
	} pvt_state_t;

	localparam int unsigned W = pvt_pkg::CNT_W;
	localparam int unsigned TW = 32;

	// Supply synchroniser
	logic sg_s1_reg;
	logic sg_s2_reg;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sg_s1_reg <= 1'b0;
			sg_s2_reg <= 1'b0;
		end else begin
			sg_s1_reg <= supply_good;
			sg_s2_reg <= sg_s1_reg;
		end
	end

	// Pixel clock divider
	logic       div_reg;
	logic       div_next;
	logic       pclk_reg;
	logic       pclk_next;
	logic       pix_en;
	always_comb begin
		div_next  = ~div_reg;
		pclk_next = pclk_reg;
		if (!sg_s2_reg) begin
			pclk_next = 1'b0;
		end else if (div_reg) begin
			pclk_next = ~pclk_reg;
		end
	end
	assign pix_en = div_reg && pclk_reg;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div_reg  <= 1'b0;
			pclk_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			pclk_reg <= pclk_next;
		end
	end

	// Sequencer state
	pvt_state_t   st_reg;
	pvt_state_t   st_next;
	logic [1:0]   mode_reg;
	logic [1:0]   mode_next;
	logic [TW-1:0] tmr_reg;
	logic [TW-1:0] tmr_next;
	logic [TW-1:0] gap_reg;
	logic [TW-1:0] gap_next;
	logic          run;
	logic          frame_end;
	logic [W-1:0]  h_cnt;
	logic [W-1:0]  v_cnt;
	logic [W-1:0]  h_total;
	logic [W-1:0]  v_total;

	always_comb begin
		st_next   = st_reg;
		mode_next = mode_reg;
		tmr_next  = (tmr_reg != '0) ? tmr_reg - TW'(1) : '0;
		gap_next  = (gap_reg != '0) ? gap_reg - TW'(1) : '0;
		case (st_reg)
			PVT_OFF: begin
				if (sg_s2_reg && enable) begin
					st_next   = PVT_RUN;
					mode_next = mode_req;
					tmr_next  = TW'(BL_CYC);
				end
			end
			PVT_RUN: begin
				// Video keeps running for the full delay after a disable
				if (!sg_s2_reg) begin
					st_next = PVT_OFF;
				end else if (tmr_reg == '0) begin
					st_next = enable ? PVT_LIGHT : PVT_OFF;
				end
			end
			PVT_LIGHT: begin
				if (!sg_s2_reg || !enable) begin
					st_next  = PVT_RUN;
					tmr_next = TW'(BL_CYC);
				end else if (mode_req[1] != mode_reg[1] && gap_reg == '0 && frame_end) begin
					st_next   = PVT_WAIT;
					mode_next = mode_req;
					tmr_next  = TW'(BLACK_CYC);
					gap_next  = TW'(GAP_CYC);
				end else if (mode_req != mode_reg && mode_req[1] == mode_reg[1]
					&& frame_end) begin
					mode_next = mode_req;
				end
			end
			PVT_WAIT: begin
				if (!sg_s2_reg || !enable) begin
					st_next = PVT_OFF;
				end else if (tmr_reg == '0) begin
					st_next = PVT_LIGHT;
				end
			end
			default: begin
				st_next = PVT_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_reg   <= PVT_OFF;
			mode_reg <= pvt_pkg::MODE_2D60;
			tmr_reg  <= '0;
			gap_reg  <= '0;
		end else begin
			st_reg   <= st_next;
			mode_reg <= mode_next;
			tmr_reg  <= tmr_next;
			gap_reg  <= gap_next;
		end
	end

	// Raster totals per mode
	always_comb begin
		h_total = W'(pvt_pkg::H_ACTIVE + H_BLANK);
		case (mode_reg)
			pvt_pkg::MODE_3D50: v_total = W'(pvt_pkg::V_ACTIVE + pvt_pkg::V_BLANK_3D50);
			pvt_pkg::MODE_3D60: v_total = W'(pvt_pkg::V_ACTIVE + pvt_pkg::V_BLANK_3D60);
			default:            v_total = W'(pvt_pkg::V_ACTIVE + V_BLANK2D);
		endcase
	end

	assign run = (st_reg != PVT_OFF) && sg_s2_reg;

	pvt_counter #(
		.W(W)
	) u_cnt (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.pix_en   (pix_en),
		.run      (run),
		.h_total  (h_total),
		.v_total  (v_total),
		.h_cnt    (h_cnt),
		.v_cnt    (v_cnt),
		.frame_end(frame_end)
	);

	// Data enable and port data
	logic             active;
	logic             de_reg;
	logic             de_next;
	logic [PIX_W-1:0] pd_reg   [4];
	logic [PIX_W-1:0] pd_next  [4];
	assign active = run && (h_cnt < W'(pvt_pkg::H_ACTIVE))
		&& (v_cnt < W'(pvt_pkg::V_ACTIVE));
	assign pix_take = pix_en && active;

	always_comb begin
		de_next = de_reg;
		if (!run) begin
			de_next = 1'b0;
		end else if (pix_en) begin
			de_next = active;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			always_comb begin
				pd_next[gi] = pd_reg[gi];
				if (!run) begin
					pd_next[gi] = '0;
				end else if (pix_en) begin
					pd_next[gi] = active ? pix_in[gi*PIX_W +: PIX_W] : '0;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!nrst) begin
					pd_reg[gi] <= '0;
				end else begin
					pd_reg[gi] <= pd_next[gi];
				end
			end
			assign port_data[gi] = pd_reg[gi];
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			de_reg <= 1'b0;
		end else begin
			de_reg <= de_next;
		end
	end

	assign pix_clk      = pclk_reg;
	assign data_en      = de_reg;
	assign backlight_on = (st_reg == PVT_LIGHT);
	assign mode_cur     = mode_reg;
	assign switch_busy  = (st_reg == PVT_WAIT) || (gap_reg != '0);

	// Backlight dark throughout a mode-change wait
	bl_dark_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_reg == PVT_WAIT) |-> !backlight_on) else $error("backlight on during switch");
	// Switch loads the gap timer
	sw_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(st_reg == PVT_LIGHT && st_next == PVT_WAIT) |=> (gap_reg == TW'(GAP_CYC)))
		else $error("gap timer not loaded");
	// No switch while gap still running
	gap_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(gap_reg != '0 && st_reg == PVT_LIGHT) |=> (mode_reg[1] == $past(mode_reg[1])))
		else $error("switch inside gap");
	// De low outside active area
	de_blank_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(data_en && $past(pix_en)) |-> $past(active)) else $error("de in blanking");
	// Data enable and backlight low without supply
	off_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!sg_s2_reg) |=> (!data_en && !backlight_on)) else $error("drive without supply");
	// Lines have fixed total
	h_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && pix_en && h_cnt == h_total - W'(1)) |=> (h_cnt == '0))
		else $error("line total wrong");
	// 3D50 vertical total fixed
	v3d_tot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(mode_reg == pvt_pkg::MODE_3D50) |-> (v_total == W'(1350))) else $error("3d50 total");
	// Port one carries the first pixel
	port_map_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pix_en && active) |=> (port_data[0] == $past(pix_in[PIX_W-1:0])))
		else $error("port mapping");
	// Pixel clock toggles every two cycles while supply is good
	pclk_tog_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sg_s2_reg && div_reg) |=> (pix_clk != $past(pix_clk))) else $error("pclk stall");
endmodule

// ---- sim/pvt_panel.sv ----
/*
 Panel model: finds pixel clock edges with its own clock, counts data
 enable clocks and line length, and shows black after a format change.
 Assumes the source drives pix_clk, data_en and port_data.
*/
`timescale 1ns/10ps
module pvt_panel #(
	parameter int unsigned PIX_W = 30,
	parameter int unsigned BLK   = 300
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	// Link from source
	input  wire logic             pix_clk,
	input  wire logic             data_en,
	input  wire logic [PIX_W-1:0] port_data [4],
	// Observed figures
	output logic      [15:0]      de_cnt,
	output logic      [15:0]      line_tot,
	output logic      [15:0]      lines,
	output logic                  black
);
	logic        clk_q;
	logic        de_q;
	logic [15:0] run_de;
	logic [15:0] run_tot;
	logic [15:0] blk_cnt;

	assign black = (blk_cnt != 16'h0000);
	always_ff @(posedge sys_clk) begin
		clk_q <= pix_clk;
		if (!nrst) begin
			de_q <= 1'b0;
			run_de <= 16'h0000;
			run_tot <= 16'h0000;
			de_cnt <= 16'h0000;
			line_tot <= 16'h0000;
			lines <= 16'h0000;
			blk_cnt <= 16'h0000;
		end else begin
			if (blk_cnt != 16'h0000) begin
				blk_cnt <= blk_cnt - 16'h0001;
			end
			if (pix_clk && !clk_q) begin
				de_q <= data_en;
				run_tot <= run_tot + 16'h0001;
				if (data_en) begin
					run_de <= run_de + 16'h0001;
				end
				if (data_en && !de_q) begin
					run_de <= 16'h0001;
					run_tot <= 16'h0001;
					line_tot <= run_tot;
					lines <= lines + 16'h0001;
					// Format change: black while tables reload
					if (line_tot != 16'h0000 && line_tot != run_tot) begin
						blk_cnt <= 16'(BLK);
					end
				end
				if (!data_en && de_q) begin
					de_cnt <= run_de;
				end
			end
		end
	end
endmodule

// ---- sim/tb_top.sv ----
/*
 Bench for the video timing source: power-up, line timing, port split,
 backlight order and supply-off levels.
 Assumes the panel model beside it and shortened sequencing counts.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
	$display("mismatch at %0t: value differs", $time); err_count++; end end
module tb_top;
	localparam int unsigned BL = 50;
	localparam int unsigned HB = 90;
	logic         sys_clk = 1'b0;
	logic         nrst = 1'b0;
	logic         supply_good = 1'b0;
	logic         enable = 1'b0;
	logic [1:0]   mode_req = pvt_pkg::MODE_2D60;
	logic [119:0] pix_in = {30'h0000444, 30'h0000333, 30'h0000222, 30'h0000111};
	logic         pix_take;
	logic         pix_clk;
	logic         data_en;
	logic [29:0]  port_data [4];
	logic         backlight_on;
	logic [1:0]   mode_cur;
	logic         switch_busy;
	logic [15:0]  de_cnt;
	logic [15:0]  line_tot;
	logic [15:0]  lines;
	logic         black;
	int           err_count = 0;
	int           n_tests = 0;

	always #10 sys_clk = ~sys_clk;

	pvt_source #(.GAP_CYC(200), .BLACK_CYC(300), .BL_CYC(BL), .H_BLANK(HB),
		.V_BLANK2D(35)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.supply_good(supply_good), .enable(enable), .mode_req(mode_req),
		.pix_in(pix_in), .pix_take(pix_take), .pix_clk(pix_clk),
		.data_en(data_en), .port_data(port_data), .backlight_on(backlight_on),
		.mode_cur(mode_cur), .switch_busy(switch_busy));
	pvt_panel panel (.sys_clk(sys_clk), .nrst(nrst),
		.pix_clk(pix_clk), .data_en(data_en), .port_data(port_data),
		.de_cnt(de_cnt), .line_tot(line_tot), .lines(lines), .black(black));

	task automatic stop_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic t_reset();
		`CHK(pix_clk, 1'b0)
		`CHK(data_en, 1'b0)
		`CHK(backlight_on, 1'b0)
		`CHK(mode_cur, 2'h1)
		`CHK(switch_busy, 1'b0)
	endtask

	task automatic t_power();
		int n;
		supply_good = 1'b1;
		enable = 1'b1;
		n = 0;
		while (backlight_on !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(n >= BL, 1'b1)
		`CHK(backlight_on, 1'b1)
		while (pix_clk !== 1'b0) @(negedge sys_clk);
		while (pix_clk !== 1'b1) @(negedge sys_clk);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (pix_clk !== 1'b0 && n < 10);
		while (pix_clk !== 1'b1 && n < 10) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(n, 4)
	endtask

	task automatic t_lines();
		int n;
		n = 0;
		while (lines < 16'h0004 && n < 30000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(de_cnt, 16'h03C0)
		`CHK(line_tot, 16'h041A)
		`CHK(black, 1'b0)
		while (data_en !== 1'b0) @(negedge sys_clk);
		while (data_en !== 1'b1) @(negedge sys_clk);
		for (int k = 0; k < 4; k++) begin
			`CHK(port_data[k], pix_in[k*30+:30])
		end
		// One line period of pixel groups taken
		n = 0;
		repeat (4 * (pvt_pkg::H_ACTIVE + HB)) begin
			@(negedge sys_clk);
			if (pix_take === 1'b1) begin
				n++;
			end
		end
		`CHK(n, pvt_pkg::H_ACTIVE)
	endtask

	task automatic t_mode();
		int n;
		int l0;
		l0 = lines;
		mode_req = pvt_pkg::MODE_3D50;
		supply_good = 1'b1;
		enable = 1'b1;
		n = 0;
		while (backlight_on !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(mode_cur, pvt_pkg::MODE_3D50)
		`CHK(switch_busy, 1'b0)
		n = 0;
		while (lines < l0 + 2 && n < 12000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(de_cnt, 16'h03C0)
		`CHK(line_tot, 16'h041A)
		`CHK(black, 1'b1)
	endtask

	task automatic t_off();
		enable = 1'b0;
		repeat (5) @(negedge sys_clk);
		`CHK(backlight_on, 1'b0)
		`CHK(data_en, 1'b1)
		while (pix_clk !== 1'b1) @(negedge sys_clk);
		`CHK(pix_clk, 1'b1)
		repeat (BL + 20) @(negedge sys_clk);
		`CHK(data_en, 1'b0)
		supply_good = 1'b0;
		repeat (10) @(negedge sys_clk);
		`CHK(pix_clk, 1'b0)
		`CHK(data_en, 1'b0)
		`CHK(port_data[0], 30'h0000000)
		`CHK(backlight_on, 1'b0)
	endtask

	initial begin
		#(100000 * 20);
		err_count++;
		stop_test();
	end

	initial begin
		repeat (20) @(negedge sys_clk);
		t_reset();
		nrst = 1'b1;
		@(negedge sys_clk);
		t_power();
		t_lines();
		t_off();
		t_mode();
		stop_test();
	end
endmodule
